// file: hw/lcas_limit_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - Upper, lower, hysteresis words per channel 1-4
// - Words 16 bits, top four read zero
// - Power-up upper full scale, lower zero
// - Channels 5-8 never alert
// - Result above upper raises alert
// - Upper alert releases N codes below
// - Result below lower raises alert
// - Lower alert releases N codes above
// - Reset code deasserts the alert pin
// - Hysteresis powers up as 2 or 8
// - All-ones hysteresis selects min/max capture
// - Status: even bits low, odd high
// - Status bits sticky until cleared
// - Reset code clears whole status
// - Writing all ones clears status
// - Alert via flag always, pin too if chosen
// - Pin function codes; reset reads back 10
// - Configuration bit 0 sets pin polarity
// - Result bit 15 carries any-channel flag
module lcas_limit_unit #(
  parameter int RES_BITS = 12  // Converter resolution, 10 or 12
) (
  input wire logic clock,                                  // 250 MHz device clock
  input wire logic rst_b,                                  // Async reset, active low
  input wire logic reg_wr_en,                              // Register write strobe
  input wire logic reg_rd_en,                              // Register read strobe
  input wire logic [lcas_pkg::ADDR_W-1:0] reg_addr,        // Register pointer
  input wire logic [lcas_pkg::REG_W-1:0] reg_wdata,        // Write data
  output logic [lcas_pkg::REG_W-1:0] reg_rdata,            // Read data
  output logic reg_rd_valid,                               // Read data valid pulse
  input wire logic result_valid,                           // New conversion result
  input wire logic [lcas_pkg::CHAN_W-1:0] result_chan,     // Channel code, 0 is channel 1
  input wire logic [lcas_pkg::VAL_W-1:0] result_data,      // Conversion value
  input wire logic busy_in,                                // Converter busy level
  output logic [lcas_pkg::REG_W-1:0] result_word,          // Flag, channel, value
  output logic alert_flag,                                 // Result-limit flag
  output logic [lcas_pkg::STAT_W-1:0] status_out,          // Violation status bits
  input wire logic alert_pin_in,                           // Pin level as seen
  output logic alert_pin_out,                              // Pin drive level
  output logic alert_pin_oe_b                              // Pin enable, low drives
);
  import lcas_pkg::*;

  localparam logic [VAL_W-1:0] FULL_SCALE = (RES_BITS == 10) ? FULL_SCALE_10 : FULL_SCALE_12;
  localparam logic [VAL_W-1:0] HYST_RESET = (RES_BITS == 10) ? HYST_RESET_10 : HYST_RESET_12;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [STAT_W-1:0] status;
    logic [REG_W-1:0] rdata;
    logic rd_valid;
    logic [REG_W-1:0] result;
    logic flag;
    logic pin_out;
    logic pin_oe_b;
  } lcas_top_state_t;

  lcas_top_state_t state_reg;
  lcas_top_state_t state_next;

  // ----------------------------------------------------------------
  // Pointer decode
  // ----------------------------------------------------------------
  // Returns hit flag and word index 0..11 of a limit-related register
  function automatic logic [4:0] limit_index(input logic [ADDR_W-1:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < LIMIT_REGS; i++) begin
      if (addr == ADDR_LIMIT_BASE + ADDR_W'(i)) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : limit_index

  // Hit flag over a word index, decoded once per use
  logic [4:0] wr_hit;
  logic [4:0] rd_hit;
  logic clear_alerts;
  // Channel 1 sits at index 0 of each array
  logic [VAL_W-1:0] upper_a [NUM_CH];
  logic [VAL_W-1:0] lower_a [NUM_CH];
  logic [VAL_W-1:0] hyst_a [NUM_CH];
  logic [NUM_CH-1:0] hi_act;
  logic [NUM_CH-1:0] lo_act;
  logic [NUM_CH-1:0] hi_ev;
  logic [NUM_CH-1:0] lo_ev;
  // Violations this cycle, already in status bit order
  logic [STAT_W-1:0] events;
  logic any_active;
  logic limit_chan;
  // Strobes decoded once and shared by status and pin
  logic cfg_write;
  logic stat_clear_write;

  assign wr_hit = limit_index(reg_addr);
  assign rd_hit = limit_index(reg_addr);
  assign cfg_write = reg_wr_en && (reg_addr == ADDR_CONFIG);
  // Reset code clears alerts, flag and status together
  assign clear_alerts = cfg_write && (reg_wdata[CFG_FUNC_LSB +: 2] == FUNC_RESET);
  assign stat_clear_write = reg_wr_en && (reg_addr == ADDR_STATUS) &&
                            (reg_wdata[STAT_W-1:0] == STATUS_CLEAR_CODE);
  // Only codes 0..3 reach a limit pair; the rest are ignored
  assign limit_chan = result_valid && (result_chan < CHAN_W'(NUM_CH));

  // ----------------------------------------------------------------
  // Per-channel limit units
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // One write strobe per channel; the word index picks the register
    logic sel;
    assign sel = reg_wr_en && wr_hit[4];
    lcas_channel #(
      .FULL_SCALE(FULL_SCALE),
      .HYST_RESET(HYST_RESET)
    ) u_ch (
      .clock(clock),
      .rst_b(rst_b),
      .wr_lower(sel && (wr_hit[3:0] == 4'(REGS_PER_CH * c + KIND_LOWER))),
      .wr_upper(sel && (wr_hit[3:0] == 4'(REGS_PER_CH * c + KIND_UPPER))),
      .wr_hyst(sel && (wr_hit[3:0] == 4'(REGS_PER_CH * c + KIND_HYST))),
      .wdata(reg_wdata[VAL_W-1:0]),
      .sample(limit_chan && (result_chan == CHAN_W'(c))),
      .sample_data(result_data),
      .clear_alerts(clear_alerts),
      .upper_q(upper_a[c]),
      .lower_q(lower_a[c]),
      .hyst_q(hyst_a[c]),
      .hi_active(hi_act[c]),
      .lo_active(lo_act[c]),
      .hi_event(hi_ev[c]),
      .lo_event(lo_ev[c])
    );
    // Even bit low limit, odd bit high limit
    assign events[2*c] = lo_ev[c];
    assign events[2*c+1] = hi_ev[c];
  end

  // Flag, and the pin under the alert function, follow any alert held on any channel
  assign any_active = |{hi_act, lo_act};

  // ----------------------------------------------------------------
  // Register file, status, flag and pin
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;

    // Pin control slice; the reset code is not stored, it reads back as alert
    if (cfg_write) begin
      if (clear_alerts) begin
        state_next.cfg = {FUNC_ALERT, reg_wdata[CFG_POL_BIT]};
      end else begin
        state_next.cfg = reg_wdata[CFG_W-1:0];
      end
    end

    // Clears first so an event in the same cycle still lands
    if (clear_alerts || stat_clear_write) begin
      state_next.status = STATUS_RESET;
    end
    state_next.status = state_next.status | events;

    // Flag mirrors any held alert on any channel
    state_next.flag = any_active && !clear_alerts;
    if (result_valid) begin
      // Low fifteen bits carry channel code and value
      state_next.result[RESULT_FLAG_BIT-1:0] = {result_chan, result_data};
    end
    state_next.result[RESULT_FLAG_BIT] = state_next.flag;

    // Pin function and polarity; released when no function chosen
    unique case (state_reg.cfg[CFG_FUNC_LSB +: 2])
      FUNC_BUSY: begin
        state_next.pin_oe_b = 1'b0;
        state_next.pin_out = busy_in ? state_reg.cfg[CFG_POL_BIT] : !state_reg.cfg[CFG_POL_BIT];
      end
      FUNC_ALERT: begin
        state_next.pin_oe_b = 1'b0;
        state_next.pin_out = (any_active && !clear_alerts) ? state_reg.cfg[CFG_POL_BIT]
                                                            : !state_reg.cfg[CFG_POL_BIT];
      end
      FUNC_NONE, FUNC_RESET: begin
        state_next.pin_oe_b = 1'b1;
        state_next.pin_out = !state_reg.cfg[CFG_POL_BIT];
      end
    endcase

    // Read path; unmapped pointers return zero
    if (reg_rd_en) begin
      state_next.rd_valid = 1'b1;
      state_next.rdata = '0;
      if (reg_addr == ADDR_STATUS) begin
        state_next.rdata = {8'h00, state_reg.status};
      end else if (reg_addr == ADDR_CONFIG) begin
        state_next.rdata = {13'h0000, state_reg.cfg};
      // Limit words return with the top nibble cleared
      end else if (rd_hit[4]) begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (rd_hit[3:0] == 4'(REGS_PER_CH * c + KIND_LOWER)) begin
            state_next.rdata = {4'h0, lower_a[c]};
          end
          if (rd_hit[3:0] == 4'(REGS_PER_CH * c + KIND_UPPER)) begin
            state_next.rdata = {4'h0, upper_a[c]};
          end
          if (rd_hit[3:0] == 4'(REGS_PER_CH * c + KIND_HYST)) begin
            state_next.rdata = {4'h0, hyst_a[c]};
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{cfg: CFG_RESET, status: STATUS_RESET, rdata: 16'h0000, rd_valid: 1'b0,
                     result: 16'h0000, flag: 1'b0, pin_out: 1'b1, pin_oe_b: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign reg_rd_valid = state_reg.rd_valid;
  assign result_word = state_reg.result;
  assign alert_flag = state_reg.flag;
  assign status_out = state_reg.status;
  assign alert_pin_out = state_reg.pin_out;
  assign alert_pin_oe_b = state_reg.pin_oe_b;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // All checks run on the device clock and rest in reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence seq_reset_code;
    clear_alerts && !result_valid;
  endsequence

  sequence seq_status_zero;
    ##1 (state_reg.status == STATUS_RESET);
  endsequence

  chk_reset_readback: assert property (seq_reset_code |=> (state_reg.cfg[2:1] == FUNC_ALERT))
    else $error("reset code did not read back as alert");

  // Status and flag both clear one cycle later; the flag is checked a cycle after that
  chk_reset_clears: assert property (seq_reset_code |-> seq_status_zero ##1 !alert_flag)
    else $error("reset code left status or flag set");

  // All-ones write empties the status
  chk_status_ones: assert property ((stat_clear_write && !result_valid) |-> seq_status_zero)
    else $error("all-ones write did not clear status");

  // A status bit only drops on one of the two clears
  chk_status_sticky: assert property (
    (|(state_reg.status & ~state_next.status)) |-> (clear_alerts || stat_clear_write))
    else $error("status bit dropped without a clear");

  // Channel comes from the raising cycle; a reset code next cycle may drop the flag
  chk_high_raise: assert property (
    (limit_chan && (hyst_a[result_chan[1:0]] != MINMAX_CODE) && (result_data > upper_a[result_chan[1:0]]))
      |=> state_reg.status[2*$past(result_chan[1:0])+1] ##1 (alert_flag || $past(clear_alerts)))
    else $error("upper violation not raised");

  // Lower violation lands in the even bit
  chk_low_raise: assert property (
    (limit_chan && (hyst_a[result_chan[1:0]] != MINMAX_CODE) && (result_data < lower_a[result_chan[1:0]]))
      |=> state_reg.status[2*$past(result_chan[1:0])])
    else $error("lower violation not raised");

  // Top nibble of every read word is zero
  chk_upper_zero: assert property (reg_rd_valid |-> (reg_rdata[15:12] == 4'h0))
    else $error("unused high bits read nonzero");

  // Channels without limits raise no event
  chk_far_quiet: assert property ((result_valid && !limit_chan) |-> (events == '0))
    else $error("channel without limits raised an event");

  // Alert function drives the chosen level while an alert is held
  chk_pin_alert: assert property (
    ((state_reg.cfg[2:1] == FUNC_ALERT) && any_active && !clear_alerts)
      |=> (alert_pin_out == $past(state_reg.cfg[0])) && !alert_pin_oe_b)
    else $error("alert pin level wrong");

  // Codes 4..7 leave the status alone
  chk_far_status: assert property (
    (result_valid && !limit_chan && !clear_alerts && !stat_clear_write) |=> $stable(state_reg.status))
    else $error("status moved on a channel without limits");

  // Busy pin follows the converter
  chk_busy_pin: assert property (
    (state_reg.cfg[2:1] == FUNC_BUSY) |=> !alert_pin_oe_b &&
      (alert_pin_out == ($past(busy_in) ? $past(state_reg.cfg[0]) : !$past(state_reg.cfg[0]))))
    else $error("busy pin level wrong");

  // No function, pin released
  chk_pin_released: assert property ((state_reg.cfg[2:1] == FUNC_NONE) |=> alert_pin_oe_b)
    else $error("pin driven with no function");

  // Reset code idles the pin at once
  chk_reset_pin: assert property (
    (clear_alerts && (state_reg.cfg[2:1] == FUNC_ALERT)) |=> (alert_pin_out == !$past(state_reg.cfg[0])))
    else $error("reset code left the pin active");

  // Held alert shows in flag and word
  chk_flag_raise: assert property (
    (any_active && !clear_alerts) |=> (alert_flag && result_word[RESULT_FLAG_BIT]))
    else $error("held alert not flagged");

  // Flag drops once nothing is held
  chk_flag_drop: assert property (!any_active |=> !alert_flag)
    else $error("flag stayed with no alert held");

  // One answer per read strobe
  chk_read_answer: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  chk_read_single: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read answer without a strobe");

  // Status reads show the held bits
  chk_status_read: assert property (
    (reg_rd_en && (reg_addr == ADDR_STATUS)) |=> (reg_rdata == {8'h00, $past(state_reg.status)}))
    else $error("status read wrong");

  // Each result fills the low word bits
  chk_result_capture: assert property (
    result_valid |=> (result_word[RESULT_FLAG_BIT-1:0] == {$past(result_chan), $past(result_data)}))
    else $error("result word not captured");

  // Other config writes are stored
  chk_config_store: assert property (
    (cfg_write && !clear_alerts) |=> (state_reg.cfg == $past(reg_wdata[CFG_W-1:0])))
    else $error("configuration not stored");

endmodule : lcas_limit_unit

// file: shared/lcas_pkg.sv
package lcas_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int VAL_W = 12;          // Used bits of a limit word
  localparam int REG_W = 16;          // Register word width
  localparam int NUM_CH = 4;          // Channels with limits
  localparam int ADDR_W = 8;          // Register pointer width
  localparam int CFG_W = 3;           // Pin control slice of the configuration
  localparam int STAT_W = 8;          // Violation status width
  localparam int CHAN_W = 3;          // Channel code width
  localparam int REGS_PER_CH = 3;     // Lower, upper, hysteresis
  localparam int LIMIT_REGS = 12;     // Limit-related words in total

  // ----------------------------------------------------------------
  // Register pointer values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h04;  // Channel c word k at base + 3c + k
  localparam int KIND_LOWER = 0;
  localparam int KIND_UPPER = 1;
  localparam int KIND_HYST = 2;

  // ----------------------------------------------------------------
  // Configuration fields and codes
  // ----------------------------------------------------------------
  localparam int CFG_POL_BIT = 0;
  localparam int CFG_FUNC_LSB = 1;
  localparam logic [1:0] FUNC_NONE = 2'b00;
  localparam logic [1:0] FUNC_BUSY = 2'b01;
  localparam logic [1:0] FUNC_ALERT = 2'b10;
  localparam logic [1:0] FUNC_RESET = 2'b11;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_CLEAR_CODE = 8'hff;
  localparam logic [11:0] FULL_SCALE_12 = 12'hfff;
  localparam logic [11:0] FULL_SCALE_10 = 12'hffc;
  localparam logic [11:0] ZERO_SCALE = 12'h000;
  localparam logic [11:0] HYST_RESET_12 = 12'h008;
  localparam logic [11:0] HYST_RESET_10 = 12'h002;
  localparam logic [11:0] MINMAX_CODE = 12'hfff;
  localparam int RESULT_FLAG_BIT = 15;

endpackage : lcas_pkg

// file: hw/lcas_channel.sv
`timescale 1ns/1ps
module lcas_channel #(
  parameter logic [11:0] FULL_SCALE = 12'hfff,
  parameter logic [11:0] HYST_RESET = 12'h008
) (
  input wire logic clock,                               // Device clock
  input wire logic rst_b,                               // Async reset, active low
  input wire logic wr_lower,                            // Host write to lower word
  input wire logic wr_upper,                            // Host write to upper word
  input wire logic wr_hyst,                             // Host write to hysteresis word
  input wire logic [lcas_pkg::VAL_W-1:0] wdata,         // Host write value
  input wire logic sample,                              // New result for this channel
  input wire logic [lcas_pkg::VAL_W-1:0] sample_data,   // Result value
  input wire logic clear_alerts,                        // Reset code written
  output logic [lcas_pkg::VAL_W-1:0] upper_q,           // Upper word
  output logic [lcas_pkg::VAL_W-1:0] lower_q,           // Lower word
  output logic [lcas_pkg::VAL_W-1:0] hyst_q,            // Hysteresis word
  output logic hi_active,                               // Upper alert held
  output logic lo_active,                               // Lower alert held
  output logic hi_event,                                // Upper violation this cycle
  output logic lo_event                                 // Lower violation this cycle
);
  import lcas_pkg::*;

  typedef struct packed {
    logic [VAL_W-1:0] upper;
    logic [VAL_W-1:0] lower;
    logic [VAL_W-1:0] hyst;
    logic hi;
    logic lo;
  } lcas_ch_state_t;

  lcas_ch_state_t state_reg;
  lcas_ch_state_t state_next;
  logic minmax;
  logic hi_release;
  logic lo_release;

  // ----------------------------------------------------------------
  // Compare and update
  // ----------------------------------------------------------------
  // Sums use one extra bit so a large hysteresis never wraps around
  always_comb begin
    state_next = state_reg;
    minmax = (state_reg.hyst == MINMAX_CODE);
    hi_event = sample && !minmax && (sample_data > state_reg.upper);
    lo_event = sample && !minmax && (sample_data < state_reg.lower);
    hi_release = ({1'b0, sample_data} + {1'b0, state_reg.hyst}) <= {1'b0, state_reg.upper};
    lo_release = {1'b0, sample_data} >= ({1'b0, state_reg.lower} + {1'b0, state_reg.hyst});
    if (clear_alerts) begin
      state_next.hi = 1'b0;
      state_next.lo = 1'b0;
    end
    if (minmax) begin
      // Capture mode keeps the span and never holds an alert
      state_next.hi = 1'b0;
      state_next.lo = 1'b0;
      if (sample && (sample_data > state_reg.upper)) begin
        state_next.upper = sample_data;
      end
      if (sample && (sample_data < state_reg.lower)) begin
        state_next.lower = sample_data;
      end
    end else if (sample) begin
      if (hi_event) begin
        state_next.hi = 1'b1;
      end else if (hi_release) begin
        state_next.hi = 1'b0;
      end
      if (lo_event) begin
        state_next.lo = 1'b1;
      end else if (lo_release) begin
        state_next.lo = 1'b0;
      end
    end
    // Host writes win over a capture in the same cycle
    if (wr_upper) begin
      state_next.upper = wdata;
    end
    if (wr_lower) begin
      state_next.lower = wdata;
    end
    if (wr_hyst) begin
      state_next.hyst = wdata;
    end
  end

  // Power-up limits span the full range
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{upper: FULL_SCALE, lower: ZERO_SCALE, hyst: HYST_RESET, hi: 1'b0, lo: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign upper_q = state_reg.upper;
  assign lower_q = state_reg.lower;
  assign hyst_q = state_reg.hyst;
  assign hi_active = state_reg.hi;
  assign lo_active = state_reg.lo;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_high_release: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg.hi && sample && !minmax && !hi_event && hi_release && !wr_hyst) |=> !state_reg.hi)
    else $error("upper alert not released after hysteresis");
  chk_low_release: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg.lo && sample && !minmax && !lo_event && lo_release && !wr_hyst) |=> !state_reg.lo)
    else $error("lower alert not released after hysteresis");
  chk_capture_max: assert property (@(posedge clock) disable iff (!rst_b)
    (minmax && sample && !wr_upper) |=>
      (state_reg.upper == (($past(sample_data) > $past(state_reg.upper)) ? $past(sample_data)
                                                                          : $past(state_reg.upper))))
    else $error("maximum capture wrong");
  chk_capture_quiet: assert property (@(posedge clock) disable iff (!rst_b)
    minmax |-> (!hi_event && !lo_event))
    else $error("alert raised in capture mode");

endmodule : lcas_channel

// file: dv/lcas_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module lcas_host_model #(
  parameter int RES_BITS = 12  // Converter resolution
) (
  input wire logic clock,  // Device clock
  output logic wr_en,      // Write strobe
  output logic rd_en,      // Read strobe
  output logic [7:0] addr, // Register pointer
  output logic [15:0] wdata // Write data
);
  // Idle port at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
  end

  // One access per call; strobes move only after a falling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    wr_en = w;
    rd_en = !w;
    addr = a;
    // Ten-bit parts keep the two unused low bits clear
    wdata = (RES_BITS == 10) ? {d[15:2], 2'b00} : d;
    @(negedge clock);
    wr_en = 1'b0;
    rd_en = 1'b0;
  endtask : acc
endmodule : lcas_host_model

// file: dv/lcas_limit_unit_tb.sv
`timescale 1ns/1ps
module lcas_limit_unit_tb;
  import lcas_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wr_en, rd_en, rd_valid, res_valid, flag, pin_out, pin_oe_b, pin_wire;
  logic [7:0] addr, status;
  logic [15:0] wdata, rdata, rword;
  logic busy = 1'b0;
  logic [2:0] chan = 3'h0;
  logic [11:0] data = 12'h000;
  logic [11:0] v;
  logic [15:0] exp_q[$];
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  initial begin
    forever #2 clock = ~clock;
  end
  // Released pin rests at its pull-up level
  assign pin_wire = pin_oe_b ? 1'b1 : pin_out;

  lcas_host_model #(.RES_BITS(12)) i_host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  lcas_limit_unit #(.RES_BITS(12)) i_dut (.clock(clock), .rst_b(rst_b), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid), .result_valid(res_valid),
    .result_chan(chan), .result_data(data), .busy_in(busy), .result_word(rword), .alert_flag(flag),
    .status_out(status), .alert_pin_in(pin_wire), .alert_pin_out(pin_out), .alert_pin_oe_b(pin_oe_b));

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Read data is settled at the falling edge; oldest note is the match
  always @(negedge clock) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(rdata, 16'hxxxx, "unexpected read");
      else chk(rdata, exp_q.pop_front(), "read");
    end
  end

  // Cut a hang short; the whole run needs well under this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("FAIL %0t timeout", $time);
      final_report();
    end
  end

  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  function automatic logic [7:0] la(input int c, input int k);
    return ADDR_LIMIT_BASE + 8'(3 * c + k);
  endfunction : la

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_host.acc(1'b0, a, 16'h0000);
  endtask : rd

  // Flag shows two cycles after the result, so wait past that
  task automatic res(input logic [2:0] c, input logic [11:0] d);
    @(negedge clock);
    res_valid = 1'b1;
    chan = c;
    data = d;
    @(negedge clock);
    res_valid = 1'b0;
    repeat (2) @(negedge clock);
  endtask : res

  task automatic obs(input logic [7:0] st, input logic fl);
    chk({6'h00, rword[15], flag, status}, {6'h00, fl, fl, st}, "status/flag");
  endtask : obs

  initial begin
    void'($urandom(32'hd3e8));
    res_valid = 1'b0;
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      rd(la(c, KIND_UPPER), 16'h0fff);
      rd(la(c, KIND_LOWER), 16'h0000);
      rd(la(c, KIND_HYST), 16'h0008);
      v = 12'($urandom);
      i_host.acc(1'b1, la(c, KIND_HYST), {4'hf, v});
      rd(la(c, KIND_HYST), {4'h0, v});
      i_host.acc(1'b1, la(c, KIND_HYST), 16'h0008);
    end
    // Alert pin, active high; upper limit on channel 1
    i_host.acc(1'b1, ADDR_CONFIG, 16'h0005);
    i_host.acc(1'b1, la(0, KIND_UPPER), 16'h0800);
    res(3'h0, 12'h800);
    obs(8'h00, 1'b0);
    res(3'h0, 12'h801);
    obs(8'h02, 1'b1);
    chk({14'h0, pin_oe_b, pin_out}, 16'h0001, "pin active");
    res(3'h0, 12'h7f9);
    obs(8'h02, 1'b1);
    res(3'h0, 12'h7f8);
    obs(8'h02, 1'b0);
    // Lower limit on channel 2 while the first bit stays
    i_host.acc(1'b1, la(1, KIND_LOWER), 16'h0100);
    res(3'h1, 12'h0ff);
    obs(8'h06, 1'b1);
    res(3'h1, 12'h107);
    obs(8'h06, 1'b1);
    res(3'h1, 12'h108);
    obs(8'h06, 1'b0);
    for (int c = 4; c < 8; c++) begin
      res(3'(c), 12'hfff);
      res(3'(c), 12'h000);
      obs(8'h06, 1'b0);
      chk(rword, {1'b0, 3'(c), 12'h000}, "result word");
    end
    i_host.acc(1'b1, ADDR_STATUS, 16'h0055);
    rd(ADDR_STATUS, 16'h0006);
    i_host.acc(1'b1, ADDR_STATUS, 16'h00ff);
    obs(8'h00, 1'b0);
    // Channel 4 upper, then the reset code
    i_host.acc(1'b1, la(3, KIND_UPPER), 16'h0400);
    res(3'h3, 12'h401);
    obs(8'h80, 1'b1);
    i_host.acc(1'b1, ADDR_CONFIG, 16'h0007);
    repeat (2) @(negedge clock);
    obs(8'h00, 1'b0);
    chk({14'h0, pin_oe_b, pin_out}, 16'h0000, "pin cleared");
    rd(ADDR_CONFIG, 16'h0005);
    // Busy function, active low, follows the converter
    i_host.acc(1'b1, ADDR_CONFIG, 16'h0002);
    busy = 1'b1;
    repeat (2) @(negedge clock);
    chk({14'h0, pin_oe_b, pin_out}, 16'h0000, "busy active");
    busy = 1'b0;
    repeat (2) @(negedge clock);
    chk({14'h0, pin_oe_b, pin_out}, 16'h0001, "busy idle");
    i_host.acc(1'b1, ADDR_CONFIG, 16'h0000);
    repeat (2) @(negedge clock);
    chk({14'h0, pin_oe_b, pin_wire}, 16'h0003, "pin released");
    // Capture mode on channel 3 keeps only new extremes
    i_host.acc(1'b1, la(2, KIND_UPPER), 16'h0100);
    i_host.acc(1'b1, la(2, KIND_LOWER), 16'h0200);
    i_host.acc(1'b1, la(2, KIND_HYST), 16'h0fff);
    res(3'h2, 12'h150);
    res(3'h2, 12'h120);
    obs(8'h00, 1'b0);
    rd(la(2, KIND_UPPER), 16'h0150);
    rd(la(2, KIND_LOWER), 16'h0120);
    repeat (4) @(negedge clock);
    chk(16'(exp_q.size()), 16'h0000, "reads outstanding");
    final_report();
  end
endmodule : lcas_limit_unit_tb
